// File: hw/adcfs_defs.svh
`ifndef ADCFS_DEFS_SVH
`define ADCFS_DEFS_SVH
// frame and word sizes
`define ADCFS_WORD_BITS   16
`define ADCFS_CTRL_BITS   5
`define ADCFS_DATA_BITS   12
// last captured control bit index and last result bit index
`define ADCFS_CTRL_LAST   3'h4
`define ADCFS_CTRL_IDLE   3'h5
`define ADCFS_WORD_LAST   5'h0f
// channel field inside the control word (first three bits shifted in)
`define ADCFS_CH_HI       4
`define ADCFS_CH_LO       2
// synchroniser lanes
`define ADCFS_SYNC_W      6
`define ADCFS_SY_SCLK     0
`define ADCFS_SY_WFS      1
`define ADCFS_SY_RFS      2
`define ADCFS_SY_DIN      3
`define ADCFS_SY_CCLK     4
`define ADCFS_SY_ROLE     5
// reset values: strobes idle high, role high (host clocks)
// serial clock lane idles high too, so no false edge follows reset
`define ADCFS_SYNC_RST    6'h27
`define ADCFS_CTRL_RST    5'h00
`define ADCFS_DATA_RST    12'h000
`endif

// File: hw/adcfs_pkg.sv
package adcfs_pkg;
  typedef logic [15:0] adcfs_word_t;
  typedef logic [4:0]  adcfs_ctrl_t;
  typedef logic [11:0] adcfs_data_t;
  typedef enum logic [2:0] {
    RD_IDLE  = 3'b001,
    RD_SHIFT = 3'b010,
    RD_DONE  = 3'b100
  } adcfs_rd_state_e;
endpackage

// File: hw/adcfs_sync2.sv
`timescale 1ns/1ps
`include "adcfs_defs.svh"
// two-stage synchroniser for the six serial, conversion clock and role pin inputs
module adcfs_sync2 (
  input  wire logic                      mclk_in,
  input  wire logic                      srst_in,
  input  wire logic [`ADCFS_SYNC_W-1:0]  async_in,
  output logic      [`ADCFS_SYNC_W-1:0]  sync_out
);
  logic [`ADCFS_SYNC_W-1:0] meta_q;
  logic [`ADCFS_SYNC_W-1:0] meta_d;
  logic [`ADCFS_SYNC_W-1:0] sync_d;

  // first stage is read only by the second
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      meta_q   <= `ADCFS_SYNC_RST;
      sync_out <= `ADCFS_SYNC_RST;
    end else begin
      meta_q   <= meta_d;
      sync_out <= sync_d;
    end
  end
endmodule // adcfs_sync2

// File: hw/adcfs_port.sv
`timescale 1ns/1ps
`include "adcfs_defs.svh"
module adcfs_port (
  input  wire logic               mclk_in,
  input  wire logic               srst_in,
  input  wire logic               interface_role_select_in,
  input  wire logic               sclk_in,
  input  wire logic               write_frame_strobe_n_in,
  input  wire logic               read_frame_strobe_n_in,
  input  wire logic               data_in_in,
  input  wire logic               conv_clk_in,
  input  wire logic               conv_done_in,
  input  wire logic               range_bipolar_in,
  input  wire adcfs_pkg::adcfs_data_t conv_result_in,
  output logic                    data_out_out,
  output logic                    sclk_out_out,
  output logic                    sclk_oe_n_out,
  output logic                    read_frame_strobe_n_out,
  output logic                    read_frame_oe_n_out,
  output logic [2:0]              channel_select_out,
  output adcfs_pkg::adcfs_ctrl_t  control_word_out,
  output logic                    control_load_out
);
  import adcfs_pkg::*;

  logic [`ADCFS_SYNC_W-1:0] sy;
  logic [`ADCFS_SYNC_W-1:0] prev_q;
  logic                     master;
  logic                     gen_sclk_q, gen_sclk_d;
  logic                     cclk_rise, gen_rise, gen_fall, ev_rise, ev_fall;
  logic                     wfs_fall, rfs_fall;
  logic [2:0]               wcnt_q, wcnt_d;
  logic [3:0]               wshift_q, wshift_d;
  adcfs_ctrl_t              ctrl_q, ctrl_d;
  logic                     load_d;
  adcfs_data_t              res_q, res_d;
  adcfs_rd_state_e          rstate_q, rstate_d;
  logic [4:0]               rcnt_q, rcnt_d;
  adcfs_word_t              rshift_q, rshift_d;
  logic                     dout_d, rfs_q, rfs_d, pend_q, pend_d, start;

  // falling edge of a sampled level
  function automatic logic fell(input logic was, input logic now);
    fell = was & ~now;
  endfunction

  // serial, conversion clock and role pins pass two flops; conv_done_in, range_bipolar_in and conv_result_in do not
  adcfs_sync2 u_sync (
    .mclk_in  (mclk_in),
    .srst_in  (srst_in),
    .async_in ({interface_role_select_in, conv_clk_in, data_in_in,
                read_frame_strobe_n_in, write_frame_strobe_n_in, sclk_in}),
    .sync_out (sy)
  );

  // edge events from the host clock or from the generated clock
  always_comb begin
    master    = ~sy[`ADCFS_SY_ROLE];
    cclk_rise = fell(sy[`ADCFS_SY_CCLK], prev_q[`ADCFS_SY_CCLK]);
    gen_rise  = cclk_rise & ~gen_sclk_q;
    gen_fall  = cclk_rise & gen_sclk_q;
    ev_rise   = master ? gen_rise : fell(sy[`ADCFS_SY_SCLK], prev_q[`ADCFS_SY_SCLK]);
    ev_fall   = master ? gen_fall : fell(prev_q[`ADCFS_SY_SCLK], sy[`ADCFS_SY_SCLK]);
    wfs_fall  = fell(prev_q[`ADCFS_SY_WFS], sy[`ADCFS_SY_WFS]);
    rfs_fall  = fell(prev_q[`ADCFS_SY_RFS], sy[`ADCFS_SY_RFS]);
    // serial clock is half the conversion clock, so both phases are even
    gen_sclk_d = cclk_rise ? ~gen_sclk_q : gen_sclk_q;
  end

  // control word capture; counter parks at idle until the next strobe fall
  always_comb begin
    wcnt_d   = wcnt_q;
    wshift_d = wshift_q;
    ctrl_d   = ctrl_q;
    load_d   = 1'b0;
    if (sy[`ADCFS_SY_WFS]) begin
      wcnt_d = `ADCFS_CTRL_IDLE;
    end else if (wfs_fall) begin
      wcnt_d = 3'h0;
    end else if (ev_fall && wcnt_q < `ADCFS_CTRL_IDLE) begin
      wshift_d = {wshift_q[2:0], sy[`ADCFS_SY_DIN]};
      wcnt_d   = wcnt_q + 3'h1;
      if (wcnt_q == `ADCFS_CTRL_LAST) begin
        ctrl_d = {wshift_q, sy[`ADCFS_SY_DIN]};
        load_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wcnt_q           <= `ADCFS_CTRL_IDLE;
      wshift_q         <= 4'h0;
      ctrl_q           <= `ADCFS_CTRL_RST;
      control_load_out <= 1'b0;
    end else begin
      wcnt_q           <= wcnt_d;
      wshift_q         <= wshift_d;
      ctrl_q           <= ctrl_d;
      control_load_out <= load_d;
    end
  end

  // result word shifter and self-clocked frame generation
  always_comb begin
    rstate_d = rstate_q;
    rcnt_d   = rcnt_q;
    rshift_d = rshift_q;
    dout_d   = data_out_out;
    rfs_d    = rfs_q;
    // ADC core gives offset binary; bipolar flips the msb
    res_d    = res_q;
    if (conv_done_in) begin
      res_d = range_bipolar_in ? {~conv_result_in[11], conv_result_in[10:0]}
                               : conv_result_in;
    end
    // set beats clear so a conversion ending at frame start is kept
    pend_d   = conv_done_in | pend_q;
    start    = master ? (pend_q & gen_rise) : rfs_fall;
    case (rstate_q)
      RD_IDLE: begin
        if (start) begin
          rshift_d = {1'b0, ctrl_q[`ADCFS_CH_HI:`ADCFS_CH_LO], res_q};
          dout_d   = 1'b0;
          rcnt_d   = 5'h00;
          rstate_d = RD_SHIFT;
          rfs_d    = ~master;
          pend_d   = conv_done_in;
        end
      end
      RD_SHIFT: begin
        if (ev_fall) begin
          rcnt_d = rcnt_q + 5'h01;
          if (rcnt_q == `ADCFS_WORD_LAST) begin
            rstate_d = RD_DONE;
          end
        end else if (ev_rise && rcnt_q != 5'h00) begin
          rshift_d = {rshift_q[14:0], 1'b0};
          dout_d   = rshift_q[14];
        end
        if (!master && sy[`ADCFS_SY_RFS]) begin
          rstate_d = RD_IDLE; // host ended the frame early
        end
      end
      RD_DONE: begin
        dout_d = 1'b0;
        if (master ? gen_rise : sy[`ADCFS_SY_RFS]) begin
          rfs_d    = 1'b1;
          rstate_d = RD_IDLE;
        end
      end
      default: begin
        rstate_d = RD_IDLE;
        rfs_d    = 1'b1;
      end
    endcase
    if (!master) begin
      rfs_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      prev_q                  <= `ADCFS_SYNC_RST;
      gen_sclk_q              <= 1'b0;
      rstate_q                <= RD_IDLE;
      rcnt_q                  <= 5'h00;
      rshift_q                <= 16'h0000;
      data_out_out            <= 1'b0;
      rfs_q                   <= 1'b1;
      pend_q                  <= 1'b0;
      res_q                   <= `ADCFS_DATA_RST;
      sclk_out_out            <= 1'b0;
      sclk_oe_n_out           <= 1'b1;
      read_frame_oe_n_out     <= 1'b1;
      read_frame_strobe_n_out <= 1'b1;
    end else begin
      prev_q                  <= sy;
      gen_sclk_q              <= gen_sclk_d;
      rstate_q                <= rstate_d;
      rcnt_q                  <= rcnt_d;
      rshift_q                <= rshift_d;
      data_out_out            <= dout_d;
      rfs_q                   <= rfs_d;
      pend_q                  <= pend_d;
      res_q                   <= res_d;
      sclk_out_out            <= gen_sclk_d;
      sclk_oe_n_out           <= sy[`ADCFS_SY_ROLE];
      read_frame_oe_n_out     <= sy[`ADCFS_SY_ROLE];
      read_frame_strobe_n_out <= rfs_d;
    end
  end

  // channel select straight from the held control word
  assign channel_select_out = ctrl_q[`ADCFS_CH_HI:`ADCFS_CH_LO];
  assign control_word_out   = ctrl_q;

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  sequence s_fifth_bit;
    !sy[`ADCFS_SY_WFS] && !wfs_fall && ev_fall && wcnt_q == `ADCFS_CTRL_LAST;
  endsequence
  sequence s_frame_open;
    rstate_q == RD_IDLE && start;
  endsequence
  sequence s_cclk_edge;
    master && cclk_rise;
  endsequence

  property p_ctrl_load;
    s_fifth_bit |=> control_load_out && ctrl_q == {$past(wshift_q), $past(sy[`ADCFS_SY_DIN])};
  endproperty
  a_ctrl_load: assert property (p_ctrl_load) else $error("control word not loaded");

  property p_ignore_extra;
    (wcnt_q == `ADCFS_CTRL_IDLE && !wfs_fall) |=> ctrl_q == $past(ctrl_q) && !control_load_out;
  endproperty
  a_ignore_extra: assert property (p_ignore_extra) else $error("extra bit changed control");

  property p_channel;
    control_load_out |-> channel_select_out == $past(wshift_q[3:1]);
  endproperty
  a_channel: assert property (p_channel) else $error("channel select wrong");

  property p_word_head;
    s_frame_open |=> !data_out_out && rshift_q[14:12] == $past(channel_select_out)
                     && rshift_q[11:0] == $past(res_q);
  endproperty
  a_word_head: assert property (p_word_head) else $error("result word layout wrong");

  property p_sixteen;
    (rstate_q == RD_SHIFT && ev_fall && rcnt_q == `ADCFS_WORD_LAST) |=> rstate_q == RD_DONE;
  endproperty
  a_sixteen: assert property (p_sixteen) else $error("frame not closed after 16 bits");

  property p_msb_first;
    (rstate_q == RD_SHIFT && !ev_fall && ev_rise && rcnt_q != 5'h00
     && !(!master && sy[`ADCFS_SY_RFS])) |=> data_out_out == $past(rshift_q[14]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("output bit order wrong");

  property p_coding;
    conv_done_in |=> res_q[11] == ($past(conv_result_in[11]) ^ $past(range_bipolar_in));
  endproperty
  a_coding: assert property (p_coding) else $error("output coding wrong");

  property p_self_strobe;
    (master and s_frame_open) |=> !read_frame_strobe_n_out ##1 !read_frame_strobe_n_out;
  endproperty
  a_self_strobe: assert property (p_self_strobe) else $error("strobe not driven low");

  property p_role_pins;
    (!sy[`ADCFS_SY_ROLE]) [*2] |-> !sclk_oe_n_out && !read_frame_oe_n_out;
  endproperty
  a_role_pins: assert property (p_role_pins) else $error("role pins not driven");

  property p_self_clock;
    s_cclk_edge |=> sclk_out_out != $past(sclk_out_out);
  endproperty
  a_self_clock: assert property (p_self_clock) else $error("serial clock not derived");
endmodule // adcfs_port

// File: dv/adcfs_host_model.sv
`timescale 1ns/1ps
// host serial port; clocks the link itself only in the host-clocked role
module adcfs_host_model (
  input  wire logic mclk_in,
  input  wire logic role_in,
  input  wire logic sclk_pin_in,
  input  wire logic rfs_pin_in,
  input  wire logic dout_in,
  output logic      sclk_out,
  output logic      wfs_n_out,
  output logic      rfs_n_out,
  output logic      din_out
);
  logic dout_h;

  // device clock edges land on mclk edges, so sample a settled copy
  always @(negedge mclk_in) dout_h <= dout_in;

  // clock stands high between frames, strobes idle high
  initial begin
    sclk_out = 1'b1;
    wfs_n_out = 1'b1;
    rfs_n_out = 1'b1;
    din_out = 1'b0;
  end

  // one frame; bits after the control word are junk the device must drop
  task automatic xfer(input logic [4:0] ctrl, input int nbits, input bit wr, input bit rd,
                      output logic [15:0] word);
    word = 16'h0000;
    if (!role_in) begin
      wait (!rfs_pin_in);
      #2;
    end
    wfs_n_out = !wr;
    if (role_in) rfs_n_out = !rd;
    #20 din_out = ctrl[4];
    for (int i = 0; i < 16; i++) begin
      if (role_in) #80 sclk_out = 1'b0;
      else @(negedge sclk_pin_in);
      word = {word[14:0], role_in ? dout_in : dout_h};
      if (role_in) #80 sclk_out = 1'b1;
      else begin
        @(posedge sclk_pin_in);
        #2;
      end
      if (i + 1 == nbits) wfs_n_out = 1'b1;  // short frame ends early
      din_out = (i < 4) ? ctrl[3 - i] : i[0];
    end
    #80 wfs_n_out = 1'b1;
    rfs_n_out = 1'b1;
    din_out = ~din_out;  // released line never shows the last bit
  endtask
endmodule // adcfs_host_model

// File: dv/test_adc_framed_serial_port.sv
`timescale 1ns/1ps
module test_adc_framed_serial_port;
  import adcfs_pkg::*;
  logic        mclk_in, srst_in, role, conv_clk, conv_done, bipolar;
  adcfs_data_t raw;
  logic        dout, dev_sclk, sclk_oe_n, dev_rfs, rfs_oe_n, load;
  logic [2:0]  chan;
  adcfs_ctrl_t ctrl;
  logic [15:0] word;
  wire         host_sclk, host_wfs_n, host_rfs_n, host_din;
  wire         sclk_pin = sclk_oe_n ? host_sclk : dev_sclk;
  wire         rfs_pin = rfs_oe_n ? host_rfs_n : dev_rfs;
  int          mismatches = 0;
  int          checks = 0;
  int          loads = 0;
  int          l0;

  adcfs_port adcfs_port_i (.mclk_in(mclk_in), .srst_in(srst_in),
    .interface_role_select_in(role), .sclk_in(sclk_pin), .write_frame_strobe_n_in(host_wfs_n),
    .read_frame_strobe_n_in(rfs_pin), .data_in_in(host_din), .conv_clk_in(conv_clk),
    .conv_done_in(conv_done), .range_bipolar_in(bipolar), .conv_result_in(raw),
    .data_out_out(dout), .sclk_out_out(dev_sclk), .sclk_oe_n_out(sclk_oe_n),
    .read_frame_strobe_n_out(dev_rfs), .read_frame_oe_n_out(rfs_oe_n),
    .channel_select_out(chan), .control_word_out(ctrl), .control_load_out(load));

  adcfs_host_model adcfs_host_model_i (.mclk_in(mclk_in), .role_in(role),
    .sclk_pin_in(sclk_pin), .rfs_pin_in(rfs_pin), .dout_in(dout), .sclk_out(host_sclk),
    .wfs_n_out(host_wfs_n), .rfs_n_out(host_rfs_n), .din_out(host_din));

  // clocks; conversion clock starts off phase with mclk
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  initial begin
    conv_clk = 1'b0;
    #13;
    forever #50 conv_clk = ~conv_clk;
  end
  // count load pulses so a double load is caught
  always @(posedge mclk_in) if (load === 1'b1) loads <= loads + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask

  task automatic pulse_conv(input adcfs_data_t r, input bit b);
    raw = r;
    bipolar = b;
    conv_done = 1'b1;
    tick(1);
    conv_done = 1'b0;
  endtask

  function automatic logic [15:0] exp_word(logic [2:0] ch, adcfs_data_t r, bit b);
    return {1'b0, ch, b ? {~r[11], r[10:0]} : r};
  endfunction

  task automatic test_channels;
    for (int ch = 0; ch < 8; ch++) begin
      l0 = loads;
      adcfs_host_model_i.xfer({3'(ch), 2'(ch) ^ 2'h2}, 16, 1'b1, 1'b0, word);
      tick(6);
      check({11'h0, ctrl}, {11'h0, 3'(ch), 2'(ch) ^ 2'h2});
      check({13'h0, chan}, 16'(ch));
      check(16'(loads - l0), 16'h0001);
    end
  endtask

  // a frame cut after three bits must leave the control word alone
  task automatic test_short;
    l0 = loads;
    adcfs_host_model_i.xfer(5'h0a, 3, 1'b1, 1'b0, word);
    tick(6);
    check(16'(loads - l0), 16'h0000);
    check({13'h0, chan}, 16'h0007);
  endtask

  task automatic test_host_read;
    adcfs_data_t tab [4] = '{12'h800, 12'h000, 12'hfff, 12'h5a3};
    for (int k = 0; k < 4; k++) begin
      pulse_conv(tab[k], k[0]);
      adcfs_host_model_i.xfer(5'h00, 16, 1'b0, 1'b1, word);
      check(word, exp_word(3'h7, tab[k], k[0]));
      check({15'h0, dout}, 16'h0000);
      tick(4);
    end
    // tied strobes: the word carries the channel held before this write
    pulse_conv(12'h3c5, 1'b0);
    adcfs_host_model_i.xfer({3'h2, 2'h1}, 16, 1'b1, 1'b1, word);
    tick(6);
    check(word, exp_word(3'h7, 12'h3c5, 1'b0));
    check({13'h0, chan}, 16'h0002);
  endtask

  task automatic test_device_role;
    role = 1'b0;
    tick(6);
    check({14'h0, sclk_oe_n, rfs_oe_n}, 16'h0000);
    pulse_conv(12'h9e7, 1'b1);
    adcfs_host_model_i.xfer({3'h6, 2'h3}, 16, 1'b1, 1'b1, word);
    tick(6);
    check(word, exp_word(3'h2, 12'h9e7, 1'b1));
    check({13'h0, chan}, 16'h0006);
    check({15'h0, dev_rfs}, 16'h0001);
  endtask

  // main sequence
  initial begin
    srst_in = 1'b1;
    role = 1'b1;
    conv_done = 1'b0;
    bipolar = 1'b0;
    raw = 12'h000;
    tick(12);
    check({3'h0, dout, sclk_oe_n, dev_rfs, rfs_oe_n, load, ctrl, chan}, 16'h0e00);
    srst_in = 1'b0;
    tick(4);
    test_channels();
    test_short();
    test_host_read();
    test_device_role();
    complete_run();
  end

  // watchdog well beyond the expected run of about 43 us
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
endmodule // test_adc_framed_serial_port
